// [rtl/dpci_controller.sv]
// Memory controller end: clock divider, command issue, write bursts and read capture
`timescale 1ns/1ns
`default_nettype none
module dpci_controller #(
   parameter int DQ_W = 8
) (
   input  wire logic                        clk,
   input  wire logic                        rst,
   dpci_if.host                             link,
   input  wire logic                        reqValid,
   output logic                             reqReady,
   input  wire dpci_pkg::dpci_req_e         reqKind,
   input  wire logic [2:0]                  reqBank,
   input  wire logic [dpci_pkg::ADDR_W-1:0] reqAddr,
   input  wire logic [8*DQ_W-1:0]           reqWrData,
   input  wire logic [7:0]                  reqWrMask,
   input  wire logic                        odtReq,
   output logic                             rdValid,
   output logic [8*DQ_W-1:0]                rdData
);
   if (!(DQ_W == 4 || DQ_W == 8)) begin : g_chk_w
      $error("DQ_W must be 4 or 8");
   end

   typedef struct packed {
      logic                        ph;
      logic                        resetN;
      logic                        cke;
      logic [3:0]                  cmd;
      logic [2:0]                  ba;
      logic [dpci_pkg::ADDR_W-1:0] addr;
      logic                        odt;
      logic                        dm;
      logic [DQ_W-1:0]             dqOut;
      logic                        dqOe;
      logic                        dqsOut;
      logic                        dqsOe;
      dpci_pkg::dpci_cst_e         st;
      logic                        isWrite;
      logic [3:0]                  cnt;
      logic [3:0]                  beat;
      logic [3:0]                  beats;
      logic [1:0]                  blMode;
      logic [8*DQ_W-1:0]           wrData;
      logic [7:0]                  wrMask;
      logic [8*DQ_W-1:0]           rdBuf;
      logic                        rdValid;
      logic [DQ_W-1:0]             dqS1;
      logic [DQ_W-1:0]             dqS2;
      logic                        dqsS1;
      logic                        dqsS2;
      logic                        dqsPrev;
   } dpci_ctl_s;

   dpci_ctl_s s_q;
   dpci_ctl_s s_d;

   // Requests are taken just before a falling clock so pins are steady at the rise
   assign reqReady = (s_q.st == dpci_pkg::CS_IDLE) && s_q.ph && s_q.resetN;

   always_comb begin
      s_d         = s_q;
      s_d.ph      = ~s_q.ph;
      s_d.resetN  = 1'b1;
      s_d.rdValid = 1'b0;
      s_d.dqS1    = link.dq;
      s_d.dqS2    = s_q.dqS1;
      s_d.dqsS1   = link.dqs;
      s_d.dqsS2   = s_q.dqsS1;
      s_d.dqsPrev = s_q.dqsS2;
      if (s_q.ph) begin
         s_d.odt = odtReq;
      end
      case (s_q.st)
         dpci_pkg::CS_IDLE: begin
            if (reqValid && reqReady) begin
               s_d.st      = dpci_pkg::CS_CMD;
               s_d.ba      = reqBank;
               s_d.addr    = reqAddr;
               s_d.cnt     = dpci_pkg::WRITE_LAT;
               s_d.wrData  = reqWrData;
               s_d.wrMask  = reqWrMask;
               s_d.isWrite = (reqKind == dpci_pkg::REQ_WR);
               s_d.beat    = 4'h0;
               s_d.beats   = dpci_pkg::burst_beats(s_q.blMode, reqAddr[dpci_pkg::BC_BIT]);
               s_d.cmd     = dpci_pkg::CMD_NOP;
               case (reqKind)
                  dpci_pkg::REQ_ACT: s_d.cmd = dpci_pkg::CMD_ACT;
                  dpci_pkg::REQ_RD:  s_d.cmd = dpci_pkg::CMD_RD;
                  dpci_pkg::REQ_WR:  s_d.cmd = dpci_pkg::CMD_WR;
                  dpci_pkg::REQ_PRE: s_d.cmd = dpci_pkg::CMD_PRE;
                  dpci_pkg::REQ_MRS: s_d.cmd = dpci_pkg::CMD_MRS;
                  dpci_pkg::REQ_REF: s_d.cmd = dpci_pkg::CMD_REF;
                  dpci_pkg::REQ_PDE: s_d.cke = 1'b0;
                  dpci_pkg::REQ_SRE: begin
                     s_d.cmd = dpci_pkg::CMD_REF;
                     s_d.cke = 1'b0;
                  end
                  default: s_d.cke = 1'b1;
               endcase
               if (reqKind == dpci_pkg::REQ_MRS && reqBank == 3'h0) begin
                  s_d.blMode = reqAddr[dpci_pkg::MR0_BL_LSB +: 2];
               end
            end
         end
         dpci_pkg::CS_CMD: begin
            if (s_q.ph) begin
               s_d.cmd = dpci_pkg::CMD_DES;
               s_d.cnt = s_q.cnt - 4'h1;
               if (s_q.cmd == dpci_pkg::CMD_WR) begin
                  s_d.st = dpci_pkg::CS_WAIT;
               end else if (s_q.cmd == dpci_pkg::CMD_RD) begin
                  s_d.st = dpci_pkg::CS_READ;
               end else begin
                  s_d.st = dpci_pkg::CS_IDLE;
               end
            end
         end
         dpci_pkg::CS_WAIT, dpci_pkg::CS_WRITE: begin
            if (!s_q.ph && s_q.st == dpci_pkg::CS_WRITE) begin
               s_d.dqsOut = ~s_q.dqsOut;
            end
            if (s_q.ph && s_q.st == dpci_pkg::CS_WAIT && s_q.cnt != 4'h1) begin
               s_d.cnt = s_q.cnt - 4'h1;
            end else if (s_q.ph && s_q.beat == s_q.beats) begin
               s_d.st     = dpci_pkg::CS_IDLE;
               s_d.dqOe   = 1'b0;
               s_d.dqsOe  = 1'b0;
               s_d.dqsOut = 1'b0;
               s_d.dm     = 1'b0;
            end else if (s_q.ph) begin
               s_d.st    = dpci_pkg::CS_WRITE;
               s_d.dqOut = s_q.wrData[s_q.beat[2:0]*DQ_W +: DQ_W];
               s_d.dm    = s_q.wrMask[s_q.beat[2:0]];
               s_d.dqOe  = 1'b1;
               s_d.dqsOe = 1'b1;
               s_d.beat  = s_q.beat + 4'h1;
            end
         end
         dpci_pkg::CS_READ: begin
            if (s_q.beat == s_q.beats) begin
               s_d.rdValid = 1'b1;
               s_d.st      = dpci_pkg::CS_IDLE;
            end else if (s_q.dqsS2 != s_q.dqsPrev) begin
               s_d.rdBuf[s_q.beat[2:0]*DQ_W +: DQ_W] = s_q.dqS2;
               s_d.beat = s_q.beat + 4'h1;
            end
         end
         default: begin
            s_d.st = dpci_pkg::CS_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s_q     <= '0;
         s_q.cke <= 1'b1;
         s_q.cmd <= dpci_pkg::CMD_DES;
         s_q.st  <= dpci_pkg::CS_IDLE;
      end else begin
         s_q <= s_d;
      end
   end

   assign link.ck        = s_q.ph;
   assign link.ckN       = ~s_q.ph;
   assign link.resetN    = s_q.resetN;
   assign link.cke       = s_q.cke;
   assign link.csN       = s_q.cmd[3];
   assign link.rasN      = s_q.cmd[2];
   assign link.casN      = s_q.cmd[1];
   assign link.weN       = s_q.cmd[0];
   assign link.ba        = s_q.ba;
   assign link.addr      = s_q.addr;
   assign link.odt       = s_q.odt;
   assign link.dm        = s_q.dm;
   assign link.dqHost    = s_q.dqOut;
   assign link.dqHostOe  = s_q.dqOe;
   assign link.dqsHost   = s_q.dqsOut;
   assign link.dqsNHost  = ~s_q.dqsOut;
   assign link.dqsHostOe = s_q.dqsOe;
   assign rdValid        = s_q.rdValid;
   assign rdData         = s_q.rdBuf;
endmodule
`default_nettype wire

// [rtl/dpci_pkg.sv]
// Shared constants, encodings and helpers for both ends of the DDR3 pin interface
package dpci_pkg;
   localparam int ADDR_W       = 15;
   localparam int BANK_W       = 3;
   localparam int NUM_BANKS    = 8;
   localparam int NUM_MR       = 4;
   localparam int AP_BIT       = 10;
   localparam int BC_BIT       = 12;
   localparam int MR0_BL_LSB   = 0;
   localparam int MR1_TERM_BIT = 2;
   localparam int MR1_TDQS_BIT = 11;
   localparam int BEATS_MAX    = 8;

   localparam logic [1:0]        BL_FIXED8  = 2'h0;
   localparam logic [1:0]        BL_OTF     = 2'h1;
   localparam logic [1:0]        BL_FIXED4  = 2'h2;
   localparam logic [3:0]        BEATS_FULL = 4'h8;
   localparam logic [3:0]        BEATS_CHOP = 4'h4;
   localparam logic [3:0]        READ_LAT   = 4'h5;
   localparam logic [3:0]        WRITE_LAT  = 4'h4;
   localparam logic [ADDR_W-1:0] MR_RESET   = 15'h0000;

   // Pin command code {csN, rasN, casN, weN}
   typedef enum logic [3:0] {
      CMD_MRS = 4'h0,
      CMD_REF = 4'h1,
      CMD_PRE = 4'h2,
      CMD_ACT = 4'h3,
      CMD_WR  = 4'h4,
      CMD_RD  = 4'h5,
      CMD_ZQ  = 4'h6,
      CMD_NOP = 4'h7,
      CMD_DES = 4'hF
   } dpci_cmd_e;

   typedef enum logic [3:0] {
      PWR_ACTIVE = 4'h1,
      PWR_PDPRE  = 4'h2,
      PWR_PDACT  = 4'h4,
      PWR_SELF   = 4'h8
   } dpci_pwr_e;

   typedef enum logic [3:0] {
      REQ_ACT = 4'h0,
      REQ_RD  = 4'h1,
      REQ_WR  = 4'h2,
      REQ_PRE = 4'h3,
      REQ_MRS = 4'h4,
      REQ_REF = 4'h5,
      REQ_PDE = 4'h6,
      REQ_PDX = 4'h7,
      REQ_SRE = 4'h8,
      REQ_SRX = 4'h9
   } dpci_req_e;

   typedef enum logic [4:0] {
      CS_IDLE  = 5'h01,
      CS_CMD   = 5'h02,
      CS_WAIT  = 5'h04,
      CS_WRITE = 5'h08,
      CS_READ  = 5'h10
   } dpci_cst_e;

   // Beats of one access from the burst mode field and the A12 level
   function automatic logic [3:0] burst_beats(input logic [1:0] mode, input logic a12);
      if (mode == BL_OTF) begin
         return a12 ? BEATS_FULL : BEATS_CHOP;
      end else if (mode == BL_FIXED4) begin
         return BEATS_CHOP;
      end
      return BEATS_FULL;
   endfunction
endpackage

// [rtl/dpci_if.sv]
// Pin bundle between memory controller and memory device, with bus resolution
`timescale 1ns/1ns
`default_nettype none
interface dpci_if #(
   parameter int DQ_W = 8
);
   logic                        ck;
   logic                        ckN;
   logic                        resetN;
   logic                        cke;
   logic                        csN;
   logic                        rasN;
   logic                        casN;
   logic                        weN;
   logic [2:0]                  ba;
   logic [dpci_pkg::ADDR_W-1:0] addr;
   logic                        odt;
   logic                        dm;
   logic [DQ_W-1:0]             dqHost;
   logic                        dqHostOe;
   logic [DQ_W-1:0]             dqDev;
   logic                        dqDevOe;
   logic                        dqsHost;
   logic                        dqsNHost;
   logic                        dqsHostOe;
   logic                        dqsDev;
   logic                        dqsNDev;
   logic                        dqsDevOe;
   logic [DQ_W-1:0]             dq;
   logic                        dqs;
   logic                        dqsN;

   // Resolved wire levels; an undriven bus reads low, its strobe complement high
   assign dq   = dqDevOe ? dqDev : (dqHostOe ? dqHost : '0);
   assign dqs  = dqsDevOe ? dqsDev : (dqsHostOe ? dqsHost : 1'b0);
   assign dqsN = dqsDevOe ? dqsNDev : (dqsHostOe ? dqsNHost : 1'b1);

   modport device (
      input  ck, ckN, resetN, cke, csN, rasN, casN, weN, ba, addr, odt, dm, dq,
      output dqDev, dqDevOe, dqsDev, dqsNDev, dqsDevOe
   );
   modport host (
      output ck, ckN, resetN, cke, csN, rasN, casN, weN, ba, addr, odt, dm,
      output dqHost, dqHostOe, dqsHost, dqsNHost, dqsHostOe,
      input  dq, dqs, dqsN
   );
endinterface
`default_nettype wire

// [rtl/dpci_device.sv]
// Memory device end: command decode, bank state, mode registers, power states, data and strobes
`timescale 1ns/1ns
`default_nettype none
module dpci_device #(
   parameter int DQ_W     = 8,
   parameter int COL_BITS = 4
) (
   dpci_if.device               link,
   output var dpci_pkg::dpci_pwr_e pwrState,
   output logic [7:0]           banksOpen,
   output logic                 termOn,
   output logic                 tdqsTermOn
);
   localparam int MEM_AW = dpci_pkg::BANK_W + COL_BITS;
   localparam int MEM_N  = 1 << MEM_AW;

   if (!(DQ_W == 4 || DQ_W == 8)) begin : g_chk_w
      $error("DQ_W must be 4 or 8");
   end
   if (COL_BITS < 4 || COL_BITS > 8) begin : g_chk_c
      $error("COL_BITS must lie in 4..8");
   end

   typedef struct packed {
      dpci_pkg::dpci_pwr_e                       pwr;
      logic [dpci_pkg::NUM_BANKS-1:0]            open;
      logic [dpci_pkg::NUM_MR-1:0][dpci_pkg::ADDR_W-1:0] mr;
      logic                                      term;
      logic                                      busy;
      logic                                      isWrite;
      logic [dpci_pkg::BANK_W-1:0]               bank;
      logic [COL_BITS-1:0]                       col;
      logic                                      autoPre;
      logic [3:0]                                timer;
      logic [3:0]                                beat;
      logic [3:0]                                beats;
      logic [DQ_W-1:0]                           dqOut;
      logic                                      dqsOut;
      logic                                      drive;
      logic                                      wake1;
      logic                                      wake2;
      logic                                      wakePrev;
      logic [MEM_N-1:0][DQ_W-1:0]                mem;
   } dpci_dev_s;

   dpci_dev_s   s_q;
   dpci_dev_s   s_d;
   logic        wakeTog_q;
   logic [3:0]  cmd;
   logic [2:0]  lowCol;
   logic [MEM_AW-1:0] idx;
   logic        tdqsEn;

   // Self-refresh exit sees the clock enable rise without any clock
   always_ff @(posedge link.cke or negedge link.resetN) begin
      if (!link.resetN) begin
         wakeTog_q <= 1'b0;
      end else begin
         wakeTog_q <= ~wakeTog_q;
      end
   end

   assign tdqsEn = (DQ_W == 8) && s_q.mr[1][dpci_pkg::MR1_TDQS_BIT];

   always_comb begin
      s_d    = s_q;
      cmd    = {link.csN, link.rasN, link.casN, link.weN};
      lowCol = s_q.col[2:0] + s_q.beat[2:0];
      idx    = {s_q.bank, s_q.col[COL_BITS-1:3], lowCol};
      s_d.wake1    = wakeTog_q;
      s_d.wake2    = s_q.wake1;
      s_d.wakePrev = s_q.wake2;
      s_d.drive    = 1'b0;

      // Burst engine: one beat per rising clock after the latency
      if (s_q.busy) begin
         if (s_q.timer != 4'h0) begin
            s_d.timer = s_q.timer - 4'h1;
         end else begin
            if (s_q.isWrite) begin
               if (!link.dm || tdqsEn) begin
                  s_d.mem[idx] = link.dq;
               end
            end else begin
               s_d.dqOut  = s_q.mem[idx];
               s_d.dqsOut = ~s_q.dqsOut;
               s_d.drive  = 1'b1;
            end
            s_d.beat = s_q.beat + 4'h1;
            if (s_q.beat == s_q.beats - 4'h1) begin
               s_d.busy = 1'b0;
               if (s_q.autoPre) begin
                  s_d.open[s_q.bank] = 1'b0;
               end
            end
         end
      end

      case (s_q.pwr)
         dpci_pkg::PWR_ACTIVE: begin
            if (!link.cke) begin
               if (cmd == dpci_pkg::CMD_REF && s_q.open == '0) begin
                  s_d.pwr = dpci_pkg::PWR_SELF;
               end else if (s_q.open == '0) begin
                  s_d.pwr = dpci_pkg::PWR_PDPRE;
               end else begin
                  s_d.pwr = dpci_pkg::PWR_PDACT;
               end
            end else if (!link.csN) begin
               if (cmd == dpci_pkg::CMD_ACT) begin
                  s_d.open[link.ba] = 1'b1;
               end else if (cmd == dpci_pkg::CMD_PRE) begin
                  if (link.addr[dpci_pkg::AP_BIT]) begin
                     s_d.open = '0;
                  end else begin
                     s_d.open[link.ba] = 1'b0;
                  end
               end else if (cmd == dpci_pkg::CMD_MRS) begin
                  if (!link.ba[2]) begin
                     s_d.mr[link.ba[1:0]] = link.addr;
                  end
               end else if ((cmd == dpci_pkg::CMD_RD || cmd == dpci_pkg::CMD_WR) && !s_q.busy) begin
                  s_d.busy    = 1'b1;
                  s_d.isWrite = (cmd == dpci_pkg::CMD_WR);
                  s_d.bank    = link.ba;
                  s_d.col     = link.addr[COL_BITS-1:0];
                  s_d.autoPre = link.addr[dpci_pkg::AP_BIT];
                  s_d.beats   = dpci_pkg::burst_beats(s_q.mr[0][dpci_pkg::MR0_BL_LSB +: 2],
                                                      link.addr[dpci_pkg::BC_BIT]);
                  s_d.beat    = 4'h0;
                  s_d.timer   = (cmd == dpci_pkg::CMD_WR) ? dpci_pkg::WRITE_LAT - 4'h1
                                                          : dpci_pkg::READ_LAT - 4'h1;
               end
            end
         end
         dpci_pkg::PWR_PDPRE, dpci_pkg::PWR_PDACT: begin
            if (link.cke) begin
               s_d.pwr = dpci_pkg::PWR_ACTIVE;
            end
         end
         dpci_pkg::PWR_SELF: begin
            if (s_q.wake2 != s_q.wakePrev) begin
               s_d.pwr = dpci_pkg::PWR_ACTIVE;
            end
         end
         default: begin
            s_d.pwr = dpci_pkg::PWR_ACTIVE;
         end
      endcase

      // Termination control buffer follows ODT when enabled in MR1, and is off in self refresh
      s_d.term = link.odt && s_q.mr[1][dpci_pkg::MR1_TERM_BIT] && (s_q.pwr != dpci_pkg::PWR_SELF);
   end

   always_ff @(posedge link.ck or negedge link.resetN) begin
      if (!link.resetN) begin
         s_q     <= '0;
         s_q.pwr <= dpci_pkg::PWR_ACTIVE;
         s_q.mr  <= {dpci_pkg::NUM_MR{dpci_pkg::MR_RESET}};
      end else begin
         s_q <= s_d;
      end
   end

   assign link.dqDev    = s_q.dqOut;
   assign link.dqDevOe  = s_q.drive;
   assign link.dqsDev   = s_q.dqsOut;
   assign link.dqsNDev  = ~s_q.dqsOut;
   assign link.dqsDevOe = s_q.drive;
   assign pwrState      = s_q.pwr;
   assign banksOpen     = s_q.open;
   assign termOn        = s_q.term;
   assign tdqsTermOn    = s_q.term && tdqsEn;
endmodule
`default_nettype wire

// [verif/dpci_checker.sv]
// Link-side assertions for the DDR3 pin bundle
`timescale 1ns/1ns
`default_nettype none
module dpci_checker (
   input wire logic ck,
   input wire logic resetN,
   input wire logic cke,
   input wire logic csN,
   input wire logic rasN,
   input wire logic casN,
   input wire logic weN,
   input wire logic dm,
   input wire logic dqHostOe,
   input wire logic dqDevOe,
   input wire logic dqsHostOe,
   input wire logic dqsDevOe,
   input wire logic dqs,
   input wire logic dqsN
);
   default clocking cb @(posedge ck); endclocking
   default disable iff (!resetN);
   logic isWr;
   logic isRd;
   assign isWr = cke && ({csN, rasN, casN, weN} == dpci_pkg::CMD_WR);
   assign isRd = cke && ({csN, rasN, casN, weN} == dpci_pkg::CMD_RD);

   no_contention_a: assert property (!(dqDevOe && dqHostOe))
      else $error("Both ends drive data");
   strobe_pair_a: assert property ((dqsDevOe || dqsHostOe) |-> dqsN == !dqs)
      else $error("Strobe pair not complementary");
   mask_in_write_a: assert property (dm |-> dqHostOe)
      else $error("Mask high outside write data");
   write_quiet_a: assert property (isWr |-> ##1 !dqDevOe [*8])
      else $error("Device drives during write");
   write_data_a: assert property (isWr |-> ##[3:6] dqHostOe)
      else $error("Write data missing");
   read_drive_a: assert property (isRd |-> ##[3:8] dqDevOe)
      else $error("Read data missing");
   read_release_a: assert property (isRd |-> ##1 !dqHostOe [*8])
      else $error("Controller drives during read");
   read_strobe_a: assert property (dqDevOe |-> dqsDevOe && $changed(dqs))
      else $error("Read data without strobe edge");
endmodule
`default_nettype wire

// [verif/test_ddr3_pin_command_interface.sv]
// Bench joining controller and device with a reference memory model
`timescale 1ns/1ns
`default_nettype none
module test_ddr3_pin_command_interface;
   logic                        clk;
   logic                        rst;
   logic                        reqValid;
   logic                        reqReady;
   dpci_pkg::dpci_req_e         reqKind;
   logic [2:0]                  reqBank;
   logic [dpci_pkg::ADDR_W-1:0] reqAddr;
   logic [63:0]                 reqWrData;
   logic [7:0]                  reqWrMask;
   logic                        odtReq;
   logic                        rdValid;
   logic [63:0]                 rdData;
   dpci_pkg::dpci_pwr_e         pwrState;
   logic [7:0]                  banksOpen;
   logic                        termOn;
   logic                        tdqsTermOn;
   logic                        tdqs;
   logic [31:0]                 seed;
   logic [7:0]                  mem [8][8];
   int                          err_total;
   int                          tests_run;

   dpci_if #(.DQ_W(8)) lnk ();
   dpci_controller #(.DQ_W(8)) i_dpci_controller (.clk(clk), .rst(rst), .link(lnk.host),
      .reqValid(reqValid), .reqReady(reqReady), .reqKind(reqKind), .reqBank(reqBank), .reqAddr(reqAddr),
      .reqWrData(reqWrData), .reqWrMask(reqWrMask), .odtReq(odtReq), .rdValid(rdValid), .rdData(rdData));
   dpci_device #(.DQ_W(8)) i_dpci_device (.link(lnk.device), .pwrState(pwrState), .banksOpen(banksOpen),
      .termOn(termOn), .tdqsTermOn(tdqsTermOn));
   dpci_checker i_dpci_checker (.ck(lnk.ck), .resetN(lnk.resetN), .cke(lnk.cke), .csN(lnk.csN),
      .rasN(lnk.rasN), .casN(lnk.casN), .weN(lnk.weN), .dm(lnk.dm), .dqHostOe(lnk.dqHostOe),
      .dqDevOe(lnk.dqDevOe), .dqsHostOe(lnk.dqsHostOe), .dqsDevOe(lnk.dqsDevOe), .dqs(lnk.dqs), .dqsN(lnk.dqsN));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic finish_test();
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Bounded wait on request ready (0) or read valid (1), sampled at the falling edge
   task automatic await(input bit useRd);
      int n;
      n = 0;
      while ((useRd ? rdValid : reqReady) !== 1'b1 && n < 300) begin
         @(negedge clk);
         n++;
      end
      if ((useRd ? rdValid : reqReady) !== 1'b1) begin
         err_total++;
         finish_test();
      end
   endtask

   task automatic req(input dpci_pkg::dpci_req_e k, input logic [2:0] b, input logic [14:0] a);
      @(negedge clk);
      reqKind = k;
      reqBank = b;
      reqAddr = a;
      reqValid = 1'b1;
      await(1'b0);
      @(negedge clk);
      reqValid = 1'b0;
   endtask

   task automatic wr(input logic [2:0] b, input logic [14:0] a, input int beats, input logic rm);
      reqWrData = {rnd(), rnd()};
      reqWrMask = rm ? 8'(rnd()) : 8'h00;
      for (int k = 0; k < beats; k++) begin
         if (!reqWrMask[k] || tdqs) mem[b][k] = reqWrData[k*8 +: 8];
      end
      req(dpci_pkg::REQ_WR, b, a);
   endtask

   task automatic rd(input logic [2:0] b, input logic [14:0] a);
      logic [63:0] e;
      for (int k = 0; k < 8; k++) e[k*8 +: 8] = mem[b][k];
      req(dpci_pkg::REQ_RD, b, a);
      await(1'b1);
      chk("rdData", e, rdData);
   endtask

   task automatic settle();
      repeat (12) @(negedge clk);
   endtask

   initial begin
      seed = 32'hDC4D0E8B;
      rst = 1'b1;
      reqValid = 1'b0;
      reqKind = dpci_pkg::REQ_REF;
      reqBank = 3'h0;
      reqAddr = '0;
      reqWrData = '0;
      reqWrMask = '0;
      odtReq = 1'b0;
      tdqs = 1'b0;
      err_total = 0;
      tests_run = 0;
      repeat (5) @(negedge clk);
      rst = 1'b0;
      req(dpci_pkg::REQ_MRS, 3'h0, 15'h0000);
      req(dpci_pkg::REQ_ACT, 3'h3, 15'(rnd()));
      settle();
      chk("banksOpen", 64'h08, 64'(banksOpen));
      wr(3'h3, 15'h1000, 8, 1'b0);
      wr(3'h3, 15'h1000, 8, 1'b1);
      rd(3'h3, 15'h1000);
      $display("test burst done");
      req(dpci_pkg::REQ_MRS, 3'h0, 15'h0001);
      wr(3'h3, 15'h0000, 4, 1'b0);
      rd(3'h3, 15'h1000);
      $display("test chop done");
      req(dpci_pkg::REQ_ACT, 3'h5, 15'(rnd()));
      req(dpci_pkg::REQ_PRE, 3'h3, 15'h0000);
      settle();
      chk("banksOpen", 64'h20, 64'(banksOpen));
      req(dpci_pkg::REQ_ACT, 3'h2, 15'(rnd()));
      req(dpci_pkg::REQ_PDE, 3'h0, 15'h0000);
      settle();
      chk("pwrState", 64'(dpci_pkg::PWR_PDACT), 64'(pwrState));
      req(dpci_pkg::REQ_PDX, 3'h0, 15'h0000);
      req(dpci_pkg::REQ_PRE, 3'h0, 15'h0400);
      settle();
      chk("banksOpen", 64'h00, 64'(banksOpen));
      req(dpci_pkg::REQ_PDE, 3'h0, 15'h0000);
      settle();
      chk("pwrState", 64'(dpci_pkg::PWR_PDPRE), 64'(pwrState));
      req(dpci_pkg::REQ_PDX, 3'h0, 15'h0000);
      req(dpci_pkg::REQ_SRE, 3'h0, 15'h0000);
      settle();
      chk("pwrState", 64'(dpci_pkg::PWR_SELF), 64'(pwrState));
      req(dpci_pkg::REQ_SRX, 3'h0, 15'h0000);
      settle();
      chk("pwrState", 64'(dpci_pkg::PWR_ACTIVE), 64'(pwrState));
      $display("test power done");
      odtReq = 1'b1;
      settle();
      chk("termOn", 64'h0, 64'(termOn));
      req(dpci_pkg::REQ_MRS, 3'h1, 15'h0004);
      settle();
      chk("termOn", 64'h1, 64'(termOn));
      odtReq = 1'b0;
      settle();
      chk("termOn", 64'h0, 64'(termOn));
      $display("test termination done");
      req(dpci_pkg::REQ_MRS, 3'h0, 15'h0002);
      req(dpci_pkg::REQ_MRS, 3'h1, 15'h0804);
      tdqs = 1'b1;
      odtReq = 1'b1;
      req(dpci_pkg::REQ_ACT, 3'h3, 15'(rnd()));
      wr(3'h3, 15'h1000, 4, 1'b1);
      rd(3'h3, 15'h1400);
      settle();
      chk("tdqsTermOn", 64'h1, 64'(tdqsTermOn));
      chk("banksOpen", 64'h00, 64'(banksOpen));
      $display("test tdqs done");
      finish_test();
   end
endmodule
`default_nettype wire
